// >>> common/ebu_defs.vh
// Constants for the external bus unit: config fields, modes, timing.
`ifndef EBU_DEFS_VH
`define EBU_DEFS_VH

// ****************************************************************
// Bus configuration word fields (default and per window)
// ****************************************************************
`define EBU_CF_WS_MSB   3        // Memory cycle wait states, 0..15
`define EBU_CF_WS_LSB   0
`define EBU_CF_TRI      4        // Memory tri-state extra cycle
`define EBU_CF_ALEL     5        // Lengthened address latch strobe
`define EBU_CF_RWD      6        // Read/write strobe delay cycle
`define EBU_CF_RDYEN    7        // Ready input extends the cycle
`define EBU_CF_MODE_MSB 9        // External bus mode
`define EBU_CF_MODE_LSB 8
`define EBU_CF_WEN      10       // Window enable (windows only)

// ****************************************************************
// External bus modes
// ****************************************************************
`define EBU_M_8DMX  2'h0         // 8-bit data, demultiplexed
`define EBU_M_8MUX  2'h1         // 8-bit data, multiplexed
`define EBU_M_16DMX 2'h2         // 16-bit data, demultiplexed
`define EBU_M_16MUX 2'h3         // 16-bit data, multiplexed

// ****************************************************************
// Window range word fields
// ****************************************************************
`define EBU_RG_BASE_MSB 15       // Base address bits A23..A12
`define EBU_RG_BASE_LSB 4
`define EBU_RG_SIZE_MSB 3        // Window size = 4 KByte << size
`define EBU_RG_SIZE_LSB 0

// ****************************************************************
// Address space and segment line counts
// ****************************************************************
`define EBU_AS_16M   2'h0
`define EBU_AS_1M    2'h1
`define EBU_AS_256K  2'h2
`define EBU_AS_64K   2'h3
`define EBU_SEG_16M  4'h8
`define EBU_SEG_1M   4'h4
`define EBU_SEG_256K 4'h2
`define EBU_SEG_64K  4'h0
`define EBU_CAN_NONE 2'h0
`define EBU_CAN_6    2'h1
`define EBU_CAN_4    2'h2
`define EBU_SEG_CAN6 4'h6
`define EBU_SEG_CAN4 4'h4

// ****************************************************************
// Synchroniser reset levels (ready_n, hold_n, hold_ack_n)
// ****************************************************************
`define EBU_SYNC_RST 3'h7

`endif

// >>> hdl/ebu_win_dec.v
// Address window decoder: prioritised window match and chip-select choice.
`timescale 1ns/100ps
`include "ebu_defs.vh"

module ebu_win_dec (
   input  wire [23:0] addr,          // Address being decoded
   input  wire [63:0] win_range,     // Four window range words
   input  wire [63:0] win_cfg,       // Four window bus config words
   input  wire [15:0] default_cfg,   // Default bus config
   output reg  [15:0] sel_cfg,       // Winning bus config
   output reg  [4:0]  sel_cs         // One-hot select, bit 0 = default
);

   // ****************************************************************
   // Per-window match
   // ****************************************************************
   wire [3:0] hit;                   // Window i covers addr

   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1) begin : g_win
         wire [15:0] rg  = win_range[16*i +: 16];
         // Size code clears low base bits, so windows are size-aligned
         wire [11:0] msk = 12'hfff << rg[`EBU_RG_SIZE_MSB:`EBU_RG_SIZE_LSB];
         assign hit[i] = win_cfg[16*i + `EBU_CF_WEN] &
                         ((addr[23:12] & msk) ==
                          (rg[`EBU_RG_BASE_MSB:`EBU_RG_BASE_LSB] & msk));
      end
   endgenerate

   // ****************************************************************
   // Priority: 4 over 3 over 2 over 1
   // ****************************************************************
   always @* begin
      if (hit[3]) begin                       // [RULE6]
         sel_cfg = win_cfg[63:48];
         sel_cs  = 5'h10;
      end else if (hit[2]) begin
         sel_cfg = win_cfg[47:32];
         sel_cs  = 5'h08;
      end else if (hit[1]) begin              // [RULE6]
         sel_cfg = win_cfg[31:16];
         sel_cs  = 5'h04;
      end else if (hit[0]) begin
         sel_cfg = win_cfg[15:0];
         sel_cs  = 5'h02;
      end else begin                          // Outside all windows [RULE7]
         sel_cfg = default_cfg;
         sel_cs  = 5'h01;
      end
   end

endmodule // ebu_win_dec

// >>> hdl/ebu_top.v
// External bus unit: bus cycle sequencer, chip selects, hold arbitration.
// Notes on behaviour
// [RULE1] Single-chip or four 8/16-bit mux/demux modes
// [RULE2] Demux: address port separate, data full/low byte
// [RULE3] Mux: address then data on shared port
// [RULE4] Cycle, tri-state, latch strobe, strobe delay programmable
// [RULE5] Four windows, each range plus config word
// [RULE6] Window 4 beats 3, 2 beats 1
// [RULE7] Unmatched addresses use default config
// [RULE8] Five chip selects: four windows plus default
// [RULE9] Unlatched bit: selects follow address directly
// [RULE10] Ready input stretches the strobe phase
// [RULE11] Hold enable hands arbitration pins to hardware
// [RULE12] After reset master, hold acknowledge driven
// [RULE13] Direction bit set: slave, acknowledge is input
// [RULE14] Segment lines 8/4/2/0 per address space
// [RULE15] CAN lines cap segment to 6/4 lines
// [RULE16] Chip selects active low, own region only
// [RULE17] Granted away: float bus, start no cycles
`timescale 1ns/100ps
`include "ebu_defs.vh"

module ebu_top (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        req,                   // Access request pulse
   input  wire        req_we,                // 1 write, 0 read
   input  wire [23:0] req_addr,              // Access address
   input  wire [15:0] req_wdata,             // Write data
   output reg         busy_r,                // Request taken, not yet acked
   output reg         ack_r,                 // Access done pulse
   output reg  [15:0] rdata_r,               // Read data, valid with ack
   input  wire        single_chip,           // No external bus
   input  wire [1:0]  addr_space,            // 16M/1M/256K/64K
   input  wire [1:0]  can_on_seg,            // CAN lines on segment port
   input  wire [15:0] default_bus_config,
   input  wire [63:0] window_range_select,
   input  wire [63:0] window_bus_config,
   input  wire        unlatched_select_bit,
   input  wire        hold_enable_bit,
   input  wire        arb_role_direction_bit,
   input  wire [15:0] shared_addr_data_port_in,
   output reg  [15:0] shared_addr_data_port_out_r,
   output reg  [15:0] shared_addr_data_port_oe_r,
   output reg  [15:0] dedicated_address_port_r,
   output reg         dedicated_address_port_oe_r,
   output reg  [7:0]  segment_addr_r,
   output reg  [7:0]  segment_addr_oe_r,
   output reg         ale_r,                 // Address latch strobe
   output reg         rd_n_r,
   output reg         wr_n_r,
   output reg         strobe_oe_r,           // Enable for ale, rd, wr, cs
   output reg  [4:0]  chip_select_n_r,       // Bit 0 default region
   input  wire        ready_n,
   input  wire        hold_n,
   input  wire        hold_acknowledge_n_in,
   output reg         hold_acknowledge_n_out_r,
   output reg         hold_acknowledge_oe_r,
   output reg         bus_request_out_n_r,
   output reg         bus_request_oe_r
);

   // ****************************************************************
   // States
   // ****************************************************************
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_ALE  = 3'h1;
   localparam [2:0] S_DLY  = 3'h2;
   localparam [2:0] S_CMD  = 3'h3;
   localparam [2:0] S_TRI  = 3'h4;
   localparam [2:0] S_HOLD = 3'h5;

   reg  [2:0]  st_r;                          // Sequencer state
   reg  [3:0]  cnt_r;                         // Phase counter
   reg         we_r;                          // Latched direction
   reg  [23:0] addr_r;                        // Latched address
   reg  [15:0] wd_r;                          // Latched write data
   reg  [15:0] cfg_r;                         // Latched bus config
   reg  [4:0]  cs_lat_r;                      // Latched select, active high
   wire [15:0] dec_cfg;
   wire [4:0]  dec_cs;
   wire [4:0]  live_cs;

   // ****************************************************************
   // Input synchronisers: 3 flops, change accepted on 2nd==3rd
   // ****************************************************************
   wire [2:0] pin_in = {hold_acknowledge_n_in, hold_n, ready_n};
   reg  [2:0] s1_r;
   reg  [2:0] s2_r;
   reg  [2:0] s3_r;
   reg  [2:0] flt_r;                          // Filtered levels
   localparam [2:0] SYNC_RST = `EBU_SYNC_RST; // Idle pin levels

   genvar k;
   generate
      for (k = 0; k < 3; k = k + 1) begin : g_sync
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               s1_r[k]  <= SYNC_RST[k];
               s2_r[k]  <= SYNC_RST[k];
               s3_r[k]  <= SYNC_RST[k];
               flt_r[k] <= SYNC_RST[k];
            end else begin
               s1_r[k] <= pin_in[k];
               s2_r[k] <= s1_r[k];
               s3_r[k] <= s2_r[k];
               // Only a level seen twice counts, glitches are dropped
               if (s2_r[k] == s3_r[k]) begin
                  flt_r[k] <= s3_r[k];
               end
            end
         end
      end
   endgenerate

   wire rdy_f  = ~flt_r[0];                   // Ready asserted
   wire hold_f = ~flt_r[1];                   // Other master asks
   wire hold_acknowledge_f = ~flt_r[2];                   // Slave: bus granted

   // ****************************************************************
   // Window decode; idle decodes request, cycle decodes latched addr
   // ****************************************************************
   wire [23:0] dec_addr = (st_r == S_IDLE) ? req_addr : addr_r;

   ebu_win_dec u_dec (
      .addr        (dec_addr),
      .win_range   (window_range_select),     // [RULE5]
      .win_cfg     (window_bus_config),
      .default_cfg (default_bus_config),
      .sel_cfg     (dec_cfg),
      .sel_cs      (dec_cs)
   );

   // ****************************************************************
   // Arbitration qualifiers
   // ****************************************************************
   wire arb_on  = hold_enable_bit;            // [RULE11]
   wire slave   = arb_on & arb_role_direction_bit;              // [RULE13]
   // Master owns unless in hold; slave owns only while granted
   wire owned   = !arb_on || (slave ? hold_acknowledge_f : (st_r != S_HOLD));
   wire pend    = busy_r | req;
   wire mode_mx = cfg_r[`EBU_CF_MODE_LSB];    // Odd modes multiplex
   wire mode_16 = cfg_r[`EBU_CF_MODE_MSB];    // Upper modes 16-bit
   wire [15:0] dmask = mode_16 ? 16'hffff : 16'h00ff;

   // ****************************************************************
   // Segment line count from address space and CAN use
   // ****************************************************************
   reg [3:0] seg_n;
   always @* begin
      case (addr_space)                       // [RULE14]
         `EBU_AS_16M:  seg_n = `EBU_SEG_16M;
         `EBU_AS_1M:   seg_n = `EBU_SEG_1M;
         `EBU_AS_256K: seg_n = `EBU_SEG_256K;
         default:      seg_n = `EBU_SEG_64K;
      endcase
      // CAN pins take the top lines away [RULE15]
      if (can_on_seg == `EBU_CAN_6 && seg_n > `EBU_SEG_CAN6) begin
         seg_n = `EBU_SEG_CAN6;
      end else if (can_on_seg == `EBU_CAN_4 && seg_n > `EBU_SEG_CAN4) begin
         seg_n = `EBU_SEG_CAN4;
      end
   end

   // We drive the bus while owned, not in hold and not in single-chip mode
   wire drive = owned && !single_chip && (st_r != S_HOLD);       // [RULE17]

   generate
      for (k = 0; k < 8; k = k + 1) begin : g_seg
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               segment_addr_oe_r[k] <= 1'b0;
            end else begin
               segment_addr_oe_r[k] <= drive && (k < seg_n);     // [RULE14]
            end
         end
      end
   endgenerate

   // ****************************************************************
   // Chip selects: latched per cycle or live
   // ****************************************************************
   assign live_cs = unlatched_select_bit ? dec_cs : cs_lat_r;    // [RULE9]

   // ****************************************************************
   // Bus cycle sequencer
   // ****************************************************************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r    <= S_IDLE;
         cnt_r   <= 4'h0;
         we_r    <= 1'b0;
         addr_r  <= 24'h000000;
         wd_r    <= 16'h0000;
         cfg_r   <= 16'h0000;
         cs_lat_r <= 5'h00;
         busy_r  <= 1'b0;
         ack_r   <= 1'b0;
         rdata_r <= 16'h0000;
         ale_r   <= 1'b0;
         rd_n_r  <= 1'b1;
         wr_n_r  <= 1'b1;
         shared_addr_data_port_out_r <= 16'h0000;
         shared_addr_data_port_oe_r  <= 16'h0000;
         dedicated_address_port_r    <= 16'h0000;
      end else begin
         ack_r <= 1'b0;
         case (st_r)
            S_IDLE: begin
               shared_addr_data_port_oe_r <= 16'h0000;
               if (req && !busy_r) begin
                  busy_r <= 1'b1;
                  we_r   <= req_we;
                  addr_r <= req_addr;
                  wd_r   <= req_wdata;
               end
               if (single_chip && pend) begin
                  // No external bus: finish without a cycle [RULE1]
                  busy_r <= 1'b0;
                  ack_r  <= 1'b1;
                  rdata_r <= 16'h0000;
               end else if (arb_on && !slave && hold_f) begin
                  st_r <= S_HOLD;             // Yield between cycles
               end else if (pend && owned && !single_chip) begin
                  if (!busy_r) begin
                     addr_r <= req_addr;
                     we_r   <= req_we;
                     wd_r   <= req_wdata;
                  end
                  cfg_r    <= dec_cfg;        // [RULE7]
                  cs_lat_r <= dec_cs;         // [RULE8]
                  ale_r    <= 1'b1;
                  dedicated_address_port_r <= busy_r ? addr_r[15:0] : req_addr[15:0];
                  if (dec_cfg[`EBU_CF_MODE_LSB]) begin
                     // Address phase on the shared port [RULE3]
                     shared_addr_data_port_out_r <= busy_r ? addr_r[15:0] : req_addr[15:0];
                     shared_addr_data_port_oe_r  <= 16'hffff;
                  end
                  cnt_r <= dec_cfg[`EBU_CF_ALEL] ? 4'h1 : 4'h0;  // [RULE4]
                  st_r  <= S_ALE;
               end
            end
            S_ALE: begin
               if (cnt_r != 4'h0) begin
                  cnt_r <= cnt_r - 4'h1;
               end else begin
                  ale_r <= 1'b0;
                  if (we_r) begin
                     // Data on full port or low byte only [RULE2]
                     shared_addr_data_port_out_r <= wd_r & dmask;
                     shared_addr_data_port_oe_r  <= dmask;
                  end else begin
                     shared_addr_data_port_oe_r  <= 16'h0000;
                  end
                  cnt_r <= cfg_r[`EBU_CF_WS_MSB:`EBU_CF_WS_LSB];
                  if (cfg_r[`EBU_CF_RWD]) begin
                     st_r <= S_DLY;           // Strobe delayed a cycle [RULE4]
                  end else begin
                     rd_n_r <= we_r;
                     wr_n_r <= !we_r;
                     st_r   <= S_CMD;
                  end
               end
            end
            S_DLY: begin
               rd_n_r <= we_r;
               wr_n_r <= !we_r;
               st_r   <= S_CMD;
            end
            S_CMD: begin
               if (cnt_r != 4'h0) begin
                  cnt_r <= cnt_r - 4'h1;      // Wait states [RULE4]
               end else if (!cfg_r[`EBU_CF_RDYEN] || rdy_f) begin    // [RULE10]
                  rd_n_r  <= 1'b1;
                  wr_n_r  <= 1'b1;
                  rdata_r <= shared_addr_data_port_in & dmask;
                  ack_r   <= 1'b1;
                  busy_r  <= 1'b0;
                  cnt_r   <= cfg_r[`EBU_CF_TRI] ? 4'h1 : 4'h0;
                  st_r    <= S_TRI;
               end
            end
            S_TRI: begin
               shared_addr_data_port_oe_r <= 16'h0000;
               if (cnt_r != 4'h0) begin
                  cnt_r <= cnt_r - 4'h1;      // Tri-state time [RULE4]
               end else begin
                  cs_lat_r <= 5'h00;
                  st_r     <= S_IDLE;
               end
            end
            S_HOLD: begin
               shared_addr_data_port_oe_r <= 16'h0000;          // [RULE17]
               if (req && !busy_r) begin
                  busy_r <= 1'b1;
                  we_r   <= req_we;
                  addr_r <= req_addr;
                  wd_r   <= req_wdata;
               end
               if (!hold_f || !arb_on || slave) begin
                  st_r <= S_IDLE;
               end
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Pin drivers
   // ****************************************************************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         segment_addr_r              <= 8'h00;
         dedicated_address_port_oe_r <= 1'b0;
         strobe_oe_r                 <= 1'b0;
         chip_select_n_r             <= 5'h1f;
         hold_acknowledge_n_out_r    <= 1'b1;
         hold_acknowledge_oe_r       <= 1'b1;   // Master drives [RULE12]
         bus_request_out_n_r         <= 1'b1;
         bus_request_oe_r            <= 1'b0;
      end else begin
         segment_addr_r <= (st_r == S_IDLE) ? req_addr[23:16] : addr_r[23:16];
         // Demux only; on from the latch cycle, with the address [RULE2]
         dedicated_address_port_oe_r <= drive && ((st_r == S_IDLE) ?
            (pend && !dec_cfg[`EBU_CF_MODE_LSB]) : !mode_mx);
         strobe_oe_r     <= drive;
         // Active low, only the decoded region [RULE16]
         chip_select_n_r <= drive ? ~live_cs : 5'h1f;
         // Acknowledge is ours as master, an input as slave [RULE13]
         hold_acknowledge_oe_r    <= !slave;
         hold_acknowledge_n_out_r <= !(arb_on && !slave && (st_r == S_HOLD));
         bus_request_oe_r         <= arb_on;    // [RULE11]
         bus_request_out_n_r      <= !(arb_on && pend && !owned);
      end
   end

endmodule // ebu_top

// >>> bench/embc_monitor.sv
// Assertions on the unit's ports.
`timescale 1ns/100ps
module embc_monitor (
   input wire        clk,
   input wire        rst_n,
   input wire        req,
   input wire        busy_r,
   input wire        ack_r,
   input wire        single_chip,
   input wire [1:0]  addr_space,
   input wire [1:0]  can_on_seg,
   input wire        ale_r,
   input wire        rd_n_r,
   input wire        wr_n_r,
   input wire        strobe_oe_r,
   input wire [4:0]  chip_select_n_r,
   input wire [7:0]  segment_addr_oe_r,
   input wire [15:0] shared_addr_data_port_oe_r,
   input wire        dedicated_address_port_oe_r,
   input wire        hold_acknowledge_n_out_r,
   input wire        hold_acknowledge_oe_r,
   input wire        arb_role_direction_bit
);
   // ****************************************************************
   // Allowed segment lines, one cycle behind
   // ****************************************************************
   reg [7:0] seg_lim_r;  // Lines that may be enabled
   always @(posedge clk) begin
      seg_lim_r <= (addr_space == 2'h0 ? 8'hff : addr_space == 2'h1 ? 8'h0f :
                    addr_space == 2'h2 ? 8'h03 : 8'h00) &
                   (can_on_seg == 2'h1 ? 8'h3f : can_on_seg == 2'h2 ? 8'h0f : 8'hff);
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   ack_pulse_a: assert property (ack_r |=> !ack_r)
      else $error("ack too long");
   busy_drop_a: assert property (ack_r |=> !busy_r)
      else $error("busy after ack");
   single_ack_a: assert property ((single_chip && req && !busy_r) |-> ##[1:2] ack_r)
      else $error("single-chip ack late");
   ext_min_a: assert property ((!single_chip && req && !busy_r) |=> !ack_r [*2])
      else $error("external access too short");
   strobe_excl_a: assert property (rd_n_r || wr_n_r)
      else $error("rd and wr both low");
   ale_first_a: assert property (($fell(rd_n_r) || $fell(wr_n_r)) |-> ($past(ale_r) || $past(ale_r, 2)))
      else $error("strobe without ale");
   cs_onehot_a: assert property ($onehot0(~chip_select_n_r))
      else $error("two selects low");
   hold_float_a: assert property ((hold_acknowledge_oe_r && !hold_acknowledge_n_out_r) |->
      (shared_addr_data_port_oe_r == 16'h0000 && !dedicated_address_port_oe_r && !strobe_oe_r))
      else $error("bus driven in hold");
   seg_lines_a: assert property ((segment_addr_oe_r & ~seg_lim_r) == 8'h00)
      else $error("segment line over limit");
   master_drive_a: assert property ((!arb_role_direction_bit && !$past(arb_role_direction_bit)) |->
      hold_acknowledge_oe_r)
      else $error("master not driving ack");
endmodule // embc_monitor

bind ebu_top embc_monitor u_mon (.*);

// >>> bench/embc_mem_model.sv
// External memory with ready delay.
`timescale 1ns/100ps
module embc_mem_model (
   input  wire        clk,
   input  wire [15:0] ad_out,     // Unit's shared port value
   input  wire [15:0] ad_oe,      // Unit's shared port enables
   input  wire [15:0] addr_port,  // Dedicated address port
   input  wire        addr_oe,    // High in demux modes
   input  wire        ale,
   input  wire        rd_n,
   input  wire        wr_n,
   input  wire        strobe_oe,
   input  wire [3:0]  slow,       // Strobe cycles before ready
   output wire [15:0] ad_in,      // Resolved shared port level
   output wire        ready_n
);
   reg  [15:0] mem_r [0:255];  // Small word store
   reg  [7:0]  addr_r;         // Latched address
   reg  [15:0] last_r;         // Last wire level
   reg  [3:0]  wait_r;         // Strobe cycle count
   wire        strobe = strobe_oe && !(rd_n && wr_n);
   // Capture address, store writes, count strobe time
   always @(posedge clk) begin
      if (ale) addr_r <= addr_oe ? addr_port[7:0] : ad_out[7:0];
      if (strobe_oe && !wr_n) mem_r[addr_r] <= ad_out & ad_oe;
      wait_r <= strobe ? wait_r + 4'h1 : 4'h0;
      last_r <= ad_in;
   end
   // Slow device holds ready off; idle level is inactive
   assign ready_n = !(strobe && wait_r >= slow);
   // Floating bits toggle so stale data never matches
   assign ad_in = (ad_out & ad_oe) |
                  (~ad_oe & ((strobe_oe && !rd_n) ? mem_r[addr_r] : ~last_r));
endmodule // embc_mem_model

// >>> bench/tb_external_memory_bus_controller.sv
// Bench: modes, windows, timing, segments, hold.
`timescale 1ns/100ps
module tb_external_memory_bus_controller;
   reg         clk, rst_n, req, req_we, single_chip, unl, hen, hold_n, dir;
   reg  [23:0] req_addr;
   reg  [15:0] req_wdata, dcfg, rd;
   reg  [1:0]  aspace, can;
   reg  [3:0]  slow;
   reg  [63:0] wrange, wcfg;
   reg  [4:0]  cs_acc;   // Selects seen low during strobe
   reg  [7:0]  seg_acc;  // Segment enables seen in access
   wire [15:0] ad_out, ad_oe, ad_in, rdata;
   wire [7:0]  seg_oe;
   wire [4:0]  cs_n;
   wire        busy, ack, ale, rd_n, wr_n, soe, dap_oe, rdy_n, hla_n, hla_oe;
   integer     errors, checks_done, lat, i;
   ebu_top DUT (.clk(clk), .rst_n(rst_n), .req(req), .req_we(req_we), .req_addr(req_addr),
      .req_wdata(req_wdata), .busy_r(busy), .ack_r(ack), .rdata_r(rdata),
      .single_chip(single_chip), .addr_space(aspace), .can_on_seg(can),
      .default_bus_config(dcfg), .window_range_select(wrange), .window_bus_config(wcfg),
      .unlatched_select_bit(unl), .hold_enable_bit(hen), .arb_role_direction_bit(dir),
      .shared_addr_data_port_in(ad_in), .shared_addr_data_port_out_r(ad_out),
      .shared_addr_data_port_oe_r(ad_oe), .dedicated_address_port_r(), .dedicated_address_port_oe_r(dap_oe),
      .segment_addr_r(), .segment_addr_oe_r(seg_oe), .ale_r(ale), .rd_n_r(rd_n), .wr_n_r(wr_n),
      .strobe_oe_r(soe), .chip_select_n_r(cs_n), .ready_n(rdy_n), .hold_n(hold_n),
      .hold_acknowledge_n_in(hla_oe ? hla_n : 1'b1), .hold_acknowledge_n_out_r(hla_n),
      .hold_acknowledge_oe_r(hla_oe), .bus_request_out_n_r(), .bus_request_oe_r());
   embc_mem_model u_mem (.clk(clk), .ad_out(ad_out), .ad_oe(ad_oe),
      .addr_port(DUT.dedicated_address_port_r), .addr_oe(dap_oe), .ale(ale), .rd_n(rd_n),
      .wr_n(wr_n), .strobe_oe(soe), .slow(slow), .ad_in(ad_in), .ready_n(rdy_n));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task chk(input [23:0] got, input [23:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // One access, bounded; gathers selects and segment enables
   task acc(input we, input [23:0] a, input [15:0] d);
      begin
         @(posedge clk);
         req <= 1'b1; req_we <= we; req_addr <= a; req_wdata <= d;
         @(posedge clk);
         req <= 1'b0;
         lat = 0; cs_acc = 5'h1f; seg_acc = 8'h00;
         while (ack !== 1'b1 && lat < 300) begin
            @(negedge clk);
            lat = lat + 1;
            seg_acc = seg_acc | seg_oe;
            if (rd_n === 1'b0 || wr_n === 1'b0) cs_acc = cs_acc & cs_n;
         end
         rd = rdata;
         if (lat >= 300) errors = errors + 1;
         @(posedge clk);
      end
   endtask
   task conclude;
      begin
         $display("checks %0d mismatches %0d", checks_done, errors);
         if (errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // Watchdog far beyond the expected run
   initial begin
      repeat (5000) @(posedge clk);
      errors = errors + 1;
      conclude;
   end
   initial begin
      rst_n = 0; req = 0; req_we = 0; req_addr = 0; req_wdata = 0; single_chip = 0;
      unl = 0; hen = 0; hold_n = 1; aspace = 0; can = 0; slow = 0; dcfg = 16'h0200; dir = 0;
      wrange = {16'h0200, 16'h0204, 16'h0100, 16'h0104};  // w4..w1, w2/w4 inside w1/w3
      wcfg = {4{16'h0600}};
      errors = 0; checks_done = 0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk(cs_n, 5'h1f);
      chk(hla_oe, 1'b1);
      $display("test reset done");
      @(posedge clk);
      single_chip <= 1'b1;
      acc(1'b0, 24'h000010, 16'h0000);
      chk(rd, 16'h0000);
      single_chip <= 1'b0;
      $display("test single chip done");
      for (i = 0; i < 4; i = i + 1) begin
         dcfg <= {6'h00, i[1:0], 8'h00};
         acc(1'b1, {21'h006000, i[1:0], 1'b0}, {14'h30e9, i[1:0]});
         acc(1'b0, {21'h006000, i[1:0], 1'b0}, 16'h0000);
         chk(rd, i[1] ? {14'h30e9, i[1:0]} : {8'h00, 6'h29, i[1:0]});
         chk(cs_acc, 5'h1e);
      end
      $display("test modes done");
      for (i = 0; i < 8; i = i + 1) begin
         unl <= i[2];
         acc(1'b0, (i[1] ? 24'h020000 : 24'h010000) | (i[0] ? 24'h000100 : 24'h008000), 16'h0);
         chk(cs_acc, 5'h1f ^ (5'h02 << i[1:0]));
      end
      $display("test windows done");
      wcfg[15:0] <= 16'h0680; slow <= 4'h6;
      acc(1'b0, 24'h018000, 16'h0000);
      chk(lat > 8, 1'b1);
      wcfg[15:0] <= 16'h0605;
      acc(1'b0, 24'h018000, 16'h0000);
      chk(lat > 7, 1'b1);
      $display("test timing done");
      for (i = 0; i < 6; i = i + 1) begin
         aspace <= (i < 4) ? i[1:0] : 2'h0;
         can <= (i < 4) ? 2'h0 : i[1:0] + 2'h1;
         acc(1'b0, 24'hfff000, 16'h0000);
         chk(seg_acc, (48'h0f3f00030fff >> (8 * i)) & 48'hff);
      end
      aspace <= 2'h0; can <= 2'h0;
      $display("test segment done");
      hen <= 1'b1; hold_n <= 1'b0;
      lat = 0;
      while (hla_n !== 1'b0 && lat < 20) begin
         @(negedge clk);
         lat = lat + 1;
      end
      chk(hla_n, 1'b0);
      chk({ad_oe, dap_oe, soe}, 18'h0);
      fork
         acc(1'b0, 24'h030000, 16'h0000);
         begin
            repeat (12) @(posedge clk);
            hold_n <= 1'b1;
         end
      join
      chk(lat > 10, 1'b1);
      dir <= 1'b1;
      repeat (2) @(negedge clk);
      chk(hla_oe, 1'b0);
      $display("test hold done");
      conclude;
   end
endmodule // tb_external_memory_bus_controller
